// [hw/ext_bus_pkg.sv]
// Constants, register map and types of the external bus unit
package ext_bus_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_DEF_CFG  = 16'hFF0C;
    localparam logic [15:0] IDX_WIN1_CFG = 16'hFF14;
    localparam logic [15:0] IDX_WIN2_CFG = 16'hFF16;
    localparam logic [15:0] IDX_WIN3_CFG = 16'hFF18;
    localparam logic [15:0] IDX_WIN4_CFG = 16'hFF1A;
    localparam logic [15:0] IDX_WIN1_SEL = 16'hFF30;
    localparam logic [15:0] IDX_WIN2_SEL = 16'hFF32;
    localparam logic [15:0] IDX_WIN3_SEL = 16'hFF34;
    localparam logic [15:0] IDX_WIN4_SEL = 16'hFF36;
    localparam logic [15:0] IDX_SYSCFG   = 16'hFF38;
    localparam logic [15:0] IDX_STATUS   = 16'hFF3A;
    localparam logic [15:0] IDX_PSWORD   = 16'hFF3C;
    // Window configuration fields
    localparam int F_WSEL_EN  = 15;
    localparam int F_RSEL_EN  = 14;
    localparam int F_WAIT_POL = 13;
    localparam int F_WAIT_EN  = 12;
    localparam int F_ACTIVE   = 10;
    localparam int F_LENGTHEN = 9;
    localparam int F_TYPE_LO  = 6;
    localparam int F_TRISTATE = 5;
    localparam int F_RWDELAY  = 4;
    localparam logic [15:0] CFG_WMASK = 16'hF6FF;
    localparam logic [15:0] WIN_CFG_RESET = 16'h0000;
    // System configuration and status word fields
    localparam int SC_SEL_TIMING = 0;
    localparam int SC_SPACE_LO   = 1;
    localparam int SC_EXT_EN     = 3;
    localparam logic [15:0] SYSCFG_WMASK = 16'h000F;
    localparam logic [15:0] SYSCFG_RESET = 16'h000E;
    localparam int PS_ARB_EN    = 0;
    localparam int PS_GRANT_DIR = 1;
    localparam logic [15:0] PSWORD_WMASK = 16'h0003;
    // Timing: half a CPU cycle is one pclk, the strobe lasts a full CPU cycle
    localparam logic [3:0] STROBE_CYCLES = 4'h2;
    localparam logic [3:0] LENGTHEN_CYCLES = 4'h2;
    // Bus types
    localparam logic [1:0] BT_8_DEMUX  = 2'h0;
    localparam logic [1:0] BT_8_MUX    = 2'h1;
    localparam logic [1:0] BT_16_DEMUX = 2'h2;
    localparam logic [1:0] BT_16_MUX   = 2'h3;
    typedef enum logic [2:0] {
        st_idle, st_addr, st_delay, st_data, st_end, st_tri, st_hold
    } bus_state_t;
endpackage : ext_bus_pkg

// [hw/external_bus_unit.sv]
// External bus unit: window decode, bus cycle sequencer, arbitration, APB registers
`timescale 1ns/1ps
module external_bus_unit
    import ext_bus_pkg::*;
#(
    parameter logic [15:0] DEF_CFG_RESET = 16'h04C0
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Internal access requests
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             req_ready,
    output logic      [15:0] req_rdata,
    // External bus pins
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n,
    output logic      [15:0] shared_out,
    output logic      [1:0]  shared_oe,
    input  wire logic [15:0] shared_in,
    output logic      [15:0] address_out,
    output logic      [7:0]  segment_out,
    output logic      [4:0]  window_select_out_n,
    input  wire logic        ready_pin,
    // Arbitration pins
    input  wire logic        hold_n_pin,
    output logic             bus_request_out_n,
    output logic             bus_grant_n_out,
    output logic             bus_grant_oe,
    input  wire logic        bus_grant_n_in
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] cfg_reg [5];
    logic [15:0] sel_reg [4];
    logic [15:0] syscfg_reg;
    logic [15:0] psword_reg;
    logic [15:0] idx;
    logic        wr_en;
    logic        mapped;
    logic [15:0] rd_val;
    logic [15:0] status_val;

    assign idx    = paddr[17:2];
    assign wr_en  = psel && penable && pwrite && mapped;
    assign pready = 1'b1;

    always_comb begin
        mapped = paddr[1:0] == 2'h0;
        rd_val = 16'h0000;
        unique case (idx)
            IDX_DEF_CFG:  rd_val = cfg_reg[0];
            IDX_WIN1_CFG: rd_val = cfg_reg[1];
            IDX_WIN2_CFG: rd_val = cfg_reg[2];
            IDX_WIN3_CFG: rd_val = cfg_reg[3];
            IDX_WIN4_CFG: rd_val = cfg_reg[4];
            IDX_WIN1_SEL: rd_val = sel_reg[0];
            IDX_WIN2_SEL: rd_val = sel_reg[1];
            IDX_WIN3_SEL: rd_val = sel_reg[2];
            IDX_WIN4_SEL: rd_val = sel_reg[3];
            IDX_SYSCFG:   rd_val = syscfg_reg;
            IDX_STATUS:   rd_val = status_val;
            IDX_PSWORD:   rd_val = psword_reg;
            default:      mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;
    assign prdata  = {16'h0000, rd_val};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg[0] <= DEF_CFG_RESET;
            for (int i = 1; i < 5; i++) cfg_reg[i] <= WIN_CFG_RESET;
            for (int i = 0; i < 4; i++) sel_reg[i] <= 16'h0000;
            syscfg_reg <= SYSCFG_RESET;
            psword_reg <= 16'h0000;
        end else if (wr_en) begin
            unique case (idx)
                IDX_DEF_CFG:  cfg_reg[0] <= pwdata[15:0] & CFG_WMASK;
                IDX_WIN1_CFG: cfg_reg[1] <= pwdata[15:0] & CFG_WMASK;
                IDX_WIN2_CFG: cfg_reg[2] <= pwdata[15:0] & CFG_WMASK;
                IDX_WIN3_CFG: cfg_reg[3] <= pwdata[15:0] & CFG_WMASK;
                IDX_WIN4_CFG: cfg_reg[4] <= pwdata[15:0] & CFG_WMASK;
                IDX_WIN1_SEL: sel_reg[0] <= pwdata[15:0];
                IDX_WIN2_SEL: sel_reg[1] <= pwdata[15:0];
                IDX_WIN3_SEL: sel_reg[2] <= pwdata[15:0];
                IDX_WIN4_SEL: sel_reg[3] <= pwdata[15:0];
                IDX_SYSCFG:   syscfg_reg <= pwdata[15:0] & SYSCFG_WMASK;
                IDX_PSWORD:   psword_reg <= pwdata[15:0] & PSWORD_WMASK;
                default:      ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] ready_ff;
    logic [1:0] hold_ff;
    logic [1:0] grant_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 2'h0;
            hold_ff  <= 2'h3;
            grant_ff <= 2'h3;
        end else begin
            ready_ff <= {ready_ff[0], ready_pin};
            hold_ff  <= {hold_ff[0], hold_n_pin};
            grant_ff <= {grant_ff[0], bus_grant_n_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window decode: base A23..A12 in [15:4], size 4 KB << [3:0]
    logic [4:1] hit;
    logic [2:0] win_sel;

    for (genvar w = 0; w < 4; w++) begin : g_win
        logic [11:0] diff;
        assign diff = req_addr[23:12] ^ sel_reg[w][15:4];
        assign hit[w+1] = cfg_reg[w+1][F_ACTIVE] &&
                          ((diff >> sel_reg[w][3:0]) == 12'h000);
    end

    always_comb begin
        if (hit[4])      win_sel = 3'h4;
        else if (hit[3]) win_sel = 3'h3;
        else if (hit[2]) win_sel = 3'h2;
        else if (hit[1]) win_sel = 3'h1;
        else             win_sel = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer
    bus_state_t  state_reg;
    bus_state_t  state_next;
    logic [3:0]  cnt_reg;
    logic [15:0] acc_cfg_reg;
    logic [23:0] acc_addr_reg;
    logic [15:0] acc_wdata_reg;
    logic        acc_wr_reg;
    logic        ext_en;
    logic        arb_en;
    logic        slave;
    logic        hold_want;
    logic        start;
    logic        wait_act;
    logic        wide;
    logic        muxed;

    assign ext_en = syscfg_reg[SC_EXT_EN];
    assign arb_en = psword_reg[PS_ARB_EN];
    assign slave  = psword_reg[PS_GRANT_DIR];
    // Slave only owns the bus while granted; master yields on a hold request
    assign hold_want = arb_en && (slave ? grant_ff[1] : !hold_ff[1]);
    assign wait_act  = ready_ff[1] == acc_cfg_reg[F_WAIT_POL];
    assign wide  = acc_cfg_reg[F_TYPE_LO+1];
    assign muxed = acc_cfg_reg[F_TYPE_LO];
    assign start = state_reg == st_idle && state_next == st_addr;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle: begin
                if (hold_want)
                    state_next = st_hold;
                else if (req_valid && ext_en)
                    state_next = st_addr;
            end
            st_addr: begin
                if (cnt_reg == 4'h0)
                    state_next = acc_cfg_reg[F_RWDELAY] ? st_delay : st_data;
            end
            st_delay: state_next = st_data;
            st_data: begin
                if (cnt_reg == 4'h0 &&
                    (!acc_cfg_reg[F_WAIT_EN] || wait_act))
                    state_next = st_end;
            end
            st_end: begin
                if (acc_cfg_reg[F_TRISTATE] && !acc_wr_reg)
                    state_next = st_tri;
                else
                    state_next = st_idle;
            end
            st_tri:  state_next = st_idle;
            st_hold: begin
                if (!hold_want)
                    state_next = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
        end else if (start) begin
            cnt_reg <= STROBE_CYCLES - 4'h1 +
                       (cfg_reg[win_sel][F_LENGTHEN] ? LENGTHEN_CYCLES : 4'h0);
        end else if (state_reg == st_addr && cnt_reg == 4'h0) begin
            cnt_reg <= acc_cfg_reg[3:0];
        end else if (cnt_reg != 4'h0 && state_reg != st_delay) begin
            // Delay cycle must not eat one of the programmed wait states
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cfg_reg   <= 16'h0000;
            acc_addr_reg  <= 24'h000000;
            acc_wdata_reg <= 16'h0000;
            acc_wr_reg    <= 1'b0;
        end else if (start) begin
            acc_cfg_reg   <= cfg_reg[win_sel];
            acc_addr_reg  <= req_addr;
            acc_wdata_reg <= req_wdata;
            acc_wr_reg    <= req_write;
        end
    end

    // Single-chip mode answers at once with zero data and no bus activity
    assign req_ready = (state_reg == st_end) ||
                       (state_reg == st_idle && req_valid && !ext_en && !hold_want);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_rdata <= 16'h0000;
        end else if (state_reg == st_end && !acc_wr_reg) begin
            req_rdata <= wide ? shared_in : {8'h00, shared_in[7:0]};
        end else if (state_reg == st_idle && req_valid && !ext_en) begin
            req_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and data pins
    logic [7:0] seg_mask;

    always_comb begin
        unique case (syscfg_reg[SC_SPACE_LO +: 2])
            2'h0: seg_mask = 8'h00;
            2'h1: seg_mask = 8'h03;
            2'h2: seg_mask = 8'h0F;
            2'h3: seg_mask = 8'hFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_out <= 16'h0000;
            segment_out <= 8'h00;
        end else if (start) begin
            address_out <= req_addr[15:0];
            segment_out <= req_addr[23:16] & seg_mask;
        end
    end

    logic next_wide;
    logic next_mux;
    logic next_wr;
    assign next_wide = start ? cfg_reg[win_sel][F_TYPE_LO+1] : wide;
    assign next_mux  = start ? cfg_reg[win_sel][F_TYPE_LO] : muxed;
    assign next_wr   = start ? req_write : acc_wr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_out <= 16'h0000;
            shared_oe  <= 2'h0;
        end else if (state_next == st_addr && next_mux) begin
            shared_out <= start ? req_addr[15:0] : acc_addr_reg[15:0];
            shared_oe  <= 2'h3;
        end else if (next_wr && (state_next == st_addr || state_next == st_delay ||
                                 state_next == st_data || state_next == st_end)) begin
            shared_out <= start ? req_wdata : acc_wdata_reg;
            shared_oe  <= next_wide ? 2'h3 : 2'h1;
        end else begin
            shared_oe  <= 2'h0;
        end
    end

    assign ale  = state_reg == st_addr;
    assign rd_n = !(!acc_wr_reg && (state_reg == st_data || state_reg == st_end));
    assign wr_n = !(acc_wr_reg && (state_reg == st_data || state_reg == st_end));

    ////////////////////////////////////////////////////////////////////////
    // Chip selects
    logic [4:0] cs_n_reg;
    logic [4:0] cs_pend;
    logic       cs_gated;
    logic       strobe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_pend <= 5'h1F;
        end else if (start) begin
            cs_pend <= ~(5'h01 << win_sel);
        end
    end

    // Late variant waits one pclk, which is half a CPU cycle here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_n_reg <= 5'h1F;
        end else if (start && syscfg_reg[SC_SEL_TIMING]) begin
            cs_n_reg <= ~(5'h01 << win_sel);
        end else if (state_reg == st_addr && cs_n_reg == 5'h1F) begin
            cs_n_reg <= cs_pend;
        end else if (state_next == st_idle || state_next == st_hold) begin
            cs_n_reg <= 5'h1F;
        end
    end

    assign strobe   = !rd_n || !wr_n;
    assign cs_gated = acc_cfg_reg[F_WSEL_EN] || acc_cfg_reg[F_RSEL_EN];
    assign window_select_out_n = cs_n_reg | {5{cs_gated && !(strobe &&
        (acc_wr_reg ? acc_cfg_reg[F_WSEL_EN] : acc_cfg_reg[F_RSEL_EN]))}};

    ////////////////////////////////////////////////////////////////////////
    // Arbitration pins and status
    assign bus_grant_oe      = !slave;
    assign bus_grant_n_out   = !(arb_en && !slave && state_reg == st_hold);
    assign bus_request_out_n = !(arb_en && state_reg == st_hold && req_valid);
    assign status_val = {9'h000, win_sel, 1'b0, state_reg};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_wait: assert property (
        state_reg == st_data && cnt_reg == 4'h0 && acc_cfg_reg[F_WAIT_EN] && !wait_act
        |=> state_reg == st_data) else $error("cycle ended without ready");
    chk_ready_end: assert property (
        state_reg == st_data && cnt_reg == 4'h0 && acc_cfg_reg[F_WAIT_EN] && wait_act
        |=> state_reg == st_end ##1 state_reg != st_end) else $error("ready not honoured");
    chk_cs_fast: assert property (
        $rose(ale) && syscfg_reg[SC_SEL_TIMING] |-> cs_n_reg != 5'h1F)
        else $error("select not with strobe");
    chk_cs_late: assert property (
        $rose(ale) && !syscfg_reg[SC_SEL_TIMING] |-> cs_n_reg == 5'h1F ##1 cs_n_reg != 5'h1F)
        else $error("select not half cycle late");
    chk_win_prio: assert property (
        start && hit[4] |=> acc_cfg_reg == $past(cfg_reg[4])) else $error("window 4 lost");
    chk_win_default: assert property (
        start && hit == 4'h0 |=> acc_cfg_reg == $past(cfg_reg[0])) else $error("no default");
    chk_hold_float: assert property (
        state_reg == st_hold |-> shared_oe == 2'h0 && cs_n_reg == 5'h1F)
        else $error("bus driven in hold");
    chk_slave_hold: assert property (
        arb_en && slave && grant_ff[1] && state_reg == st_idle |=> state_reg == st_hold)
        else $error("slave kept bus without grant");
    chk_byte_lane: assert property (
        state_reg == st_data && acc_wr_reg && !wide |-> shared_oe == 2'h1)
        else $error("high byte driven");
    chk_mux_addr: assert property (
        state_reg == st_addr && muxed |-> shared_out == acc_addr_reg[15:0])
        else $error("muxed address missing");
    chk_ale_len: assert property (
        $rose(ale) && !acc_cfg_reg[F_LENGTHEN] |-> ale [*2] ##1 !ale)
        else $error("strobe length wrong");

    cov_wait_cycle: cover property (state_reg == st_data && !wait_act ##1 state_reg == st_end);
    cov_hold: cover property (state_reg == st_idle ##1 state_reg == st_hold);
    cov_mux_read: cover property (start ##[1:20] state_reg == st_end && muxed && !acc_wr_reg);

endmodule : external_bus_unit

// [dv/ext_mem_model.sv]
// External memory model: answers reads on the shared port and drives ready
`timescale 1ns/1ps
module ext_mem_model (
    // Clock
    input  wire logic        pclk,
    // Strobes and address from the unit
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] address_out,
    // Bench controls
    input  wire logic        wait_pol,
    input  wire logic [3:0]  wait_lat,
    // Pins back to the unit
    output logic      [15:0] shared_in,
    output logic             ready_pin
);
    logic       [3:0]  cnt_reg;
    logic       [15:0] last_reg = 16'h0000;
    logic              strobe;

    assign strobe = !(rd_n && wr_n);
    always_ff @(posedge pclk) begin
        cnt_reg <= !strobe ? 4'h0 : ((cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1);
    end
    // Ready goes active only after the requested latency, never early
    assign ready_pin = (strobe && cnt_reg >= wait_lat) ? wait_pol : ~wait_pol;
    always_ff @(posedge pclk) begin
        last_reg <= shared_in;
    end
    // Released port shows the inverse of the last value so stale data cannot pass
    assign shared_in = !rd_n ? (address_out ^ 16'h5A5A) : ~last_reg;
endmodule : ext_mem_model

// [dv/testbench.sv]
// Self-checking bench for the external bus unit
`timescale 1ns/1ps
module testbench;
    import ext_bus_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        req_valid = 1'b0, req_write = 1'b0, req_ready, err;
    logic [23:0] req_addr = 24'h000000;
    logic [15:0] req_wdata = 16'h0000, req_rdata, shared_out, shared_in, address_out;
    logic [15:0] sh_ale, ad_ale, rdat, wd_seen;
    logic        ale, rd_n, wr_n, ready_pin, hold_n_pin = 1'b1, bus_request_out_n;
    logic        bus_grant_n_out, bus_grant_oe, bus_grant_n_in = 1'b0, seen_ale;
    logic        wait_pol = 1'b0;
    logic [3:0]  wait_lat = 4'h0;
    logic [1:0]  shared_oe, oe_seen;
    logic [7:0]  segment_out, seg_ale;
    logic [4:0]  window_select_out_n, sel_ale, sel_all;
    int          n_mismatch = 0, num_checks = 0, n_cyc, n_a, i;
    logic [15:0] idxs[6] = '{IDX_DEF_CFG, IDX_WIN1_CFG, IDX_WIN2_CFG, IDX_WIN3_CFG,
                             IDX_WIN4_CFG, IDX_SYSCFG};
    logic [15:0] exps[6] = '{16'h04C0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000E};
    logic [7:0]  segs[4] = '{8'h00, 8'h03, 8'h0B, 8'hAB};

    external_bus_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .req_rdata(req_rdata), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .shared_out(shared_out), .shared_oe(shared_oe),
        .shared_in(shared_in), .address_out(address_out), .segment_out(segment_out),
        .window_select_out_n(window_select_out_n), .ready_pin(ready_pin),
        .hold_n_pin(hold_n_pin), .bus_request_out_n(bus_request_out_n),
        .bus_grant_n_out(bus_grant_n_out), .bus_grant_oe(bus_grant_oe),
        .bus_grant_n_in(bus_grant_n_in));
    ext_mem_model i_mem (.pclk(pclk), .rd_n(rd_n), .wr_n(wr_n), .address_out(address_out),
        .wait_pol(wait_pol), .wait_lat(wait_lat), .shared_in(shared_in), .ready_pin(ready_pin));

    initial begin
        forever #2 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Samples pins at the first edge that sees the address strobe
    task automatic acc(input logic [23:0] a);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_addr <= a;
        n_cyc = 0;
        seen_ale = 1'b0;
        sel_all = 5'h1F;
        wd_seen = 16'h0000;
        oe_seen = 2'h0;
        do begin
            @(posedge pclk);
            n_cyc++;
            sel_all &= window_select_out_n;
            if (wr_n === 1'b0) begin
                wd_seen = shared_out;
                oe_seen = shared_oe;
            end
            if (ale === 1'b1 && !seen_ale) begin
                seen_ale = 1'b1;
                sel_ale = window_select_out_n;
                seg_ale = segment_out;
                sh_ale = shared_out;
                ad_ale = address_out;
            end
        end while (req_ready !== 1'b1 && n_cyc < 200);
        req_valid <= 1'b0;
        if (n_cyc >= 200) begin
            n_mismatch++;
            tally_and_finish();
        end
        @(posedge pclk);
        rdat = req_rdata;
    endtask : acc
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("grant_oe", bus_grant_oe, 1);
        chk("selects", window_select_out_n, 5'h1F);
        foreach (idxs[j]) begin
            apb(0, idxs[j], 16'h0000);
            chk("reg_reset", rd, exps[j]);
        end
        apb(1, IDX_WIN2_CFG, 16'hFFFF);
        apb(0, IDX_WIN2_CFG, 16'h0000);
        chk("cfg_fields", rd, 32'h0000F6FF);
        apb(1, 16'hFF00, 16'h1234);
        chk("unmapped_err", err, 1);
        $display("Test done: registers");
        apb(1, IDX_WIN1_SEL, 16'h1000);
        apb(1, IDX_WIN2_SEL, 16'h1000);
        apb(1, IDX_WIN3_SEL, 16'h2000);
        apb(1, IDX_WIN4_SEL, 16'h2000);
        apb(1, IDX_WIN1_CFG, 16'h0400);
        apb(1, IDX_WIN2_CFG, 16'h0000);
        req_addr <= 24'h100234;
        apb(0, IDX_STATUS, 16'h0000);
        chk("win_only1", 32'(rd[6:4]), 1);
        apb(1, IDX_WIN2_CFG, 16'h0400);
        apb(0, IDX_STATUS, 16'h0000);
        chk("win2_over1", 32'(rd[6:4]), 2);
        apb(1, IDX_WIN3_CFG, 16'h0400);
        apb(1, IDX_WIN4_CFG, 16'h0400);
        req_addr <= 24'h200010;
        apb(0, IDX_STATUS, 16'h0000);
        chk("win4_over3", 32'(rd[6:4]), 4);
        acc(24'h200010);
        chk("win4_select", sel_all[4], 0);
        apb(1, IDX_WIN4_CFG, 16'h0000);
        apb(0, IDX_STATUS, 16'h0000);
        chk("win4_inactive", 32'(rd[6:4]), 3);
        req_addr <= 24'h300000;
        apb(0, IDX_STATUS, 16'h0000);
        chk("default_win", 32'(rd[6:4]), 0);
        apb(1, IDX_WIN2_CFG, 16'h0000);
        $display("Test done: decode");
        for (i = 0; i < 4; i++) begin
            apb(1, IDX_WIN1_CFG, 16'h1400 | 16'(i << 6) | 16'(i[0] << 13));
            wait_pol <= i[0];
            wait_lat <= 4'h0;
            acc(24'h100234);
            n_a = n_cyc;
            chk("rdata", rdat, i[1] ? 16'h586E : 16'h006E);
            chk("win1_select", sel_all[1], 0);
            chk("addr_port", ad_ale, 16'h0234);
            if (i[0]) chk("shared_addr", sh_ale[7:0], 8'h34);
            wait_lat <= 4'h4;
            acc(24'h100234);
            chk("ready_wait", n_cyc - n_a, 4);
        end
        $display("Test done: modes and ready");
        apb(1, IDX_WIN1_CFG, 16'h04C0);
        acc(24'h100234);
        n_a = n_cyc;
        chk("base_cycle", n_a, 5);
        apb(1, IDX_WIN1_CFG, 16'h04D0);
        acc(24'h100234);
        chk("rw_delay", n_cyc - n_a, 1);
        apb(1, IDX_WIN1_CFG, 16'h04C3);
        acc(24'h100234);
        chk("wait_states", n_cyc - n_a, 3);
        apb(1, IDX_WIN1_CFG, 16'h06C0);
        acc(24'h100234);
        chk("lengthen", n_cyc - n_a, 2);
        $display("Test done: timing");
        req_write <= 1'b1;
        req_wdata <= 16'hC3A5;
        for (i = 0; i < 2; i++) begin
            apb(1, IDX_WIN1_CFG, 16'h0400 | 16'(i << 7));
            acc(24'h100234);
            chk("wr_low", wd_seen[7:0], 8'hA5);
            chk("wr_lanes", oe_seen, i ? 2'h3 : 2'h1);
            if (i) chk("wr_high", wd_seen[15:8], 8'hC3);
        end
        req_write <= 1'b0;
        $display("Test done: writes");
        for (i = 0; i < 4; i++) begin
            apb(1, IDX_SYSCFG, 16'h0008 | 16'(i << 1) | 16'(i[0]));
            acc(24'hAB1234);
            chk("segment", seg_ale, segs[i]);
            chk("select_timing", sel_ale[0], !i[0]);
        end
        apb(1, IDX_WIN1_CFG, 16'h44C0);
        acc(24'h100234);
        chk("gated_addr", sel_ale[1], 1);
        chk("gated_read", sel_all[1], 0);
        apb(1, IDX_SYSCFG, 16'h0006);
        acc(24'hAB1234);
        chk("single_chip_len", n_cyc, 1);
        chk("single_chip_ale", seen_ale, 0);
        apb(1, IDX_SYSCFG, 16'h000E);
        $display("Test done: space and selects");
        apb(1, IDX_PSWORD, 16'h0001);
        hold_n_pin <= 1'b0;
        for (i = 0; i < 20 && bus_grant_n_out !== 1'b0; i++) @(posedge pclk);
        chk("grant_low", bus_grant_n_out, 0);
        chk("grant_driven", bus_grant_oe, 1);
        req_valid <= 1'b1;
        @(posedge pclk);
        chk("request_low", bus_request_out_n, 0);
        hold_n_pin <= 1'b1;
        for (i = 0; i < 20 && bus_grant_n_out !== 1'b1; i++) @(posedge pclk);
        chk("grant_high", bus_grant_n_out, 1);
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge pclk);
        chk("held_req_done", req_ready, 1);
        req_valid <= 1'b0;
        apb(1, IDX_PSWORD, 16'h0003);
        @(posedge pclk);
        chk("slave_input", bus_grant_oe, 0);
        bus_grant_n_in <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(0, IDX_STATUS, 16'h0000);
        chk("slave_hold", 32'(rd[2:0]), 6);
        bus_grant_n_in <= 1'b0;
        $display("Test done: arbitration");
        tally_and_finish();
    end
endmodule : testbench
